// ### hdl/tlrx_port_io.sv
// Tributary receive/transmit port logic, line receive sampling and APB registers
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - One data and one clock output per tributary channel, 28 or 16/21.
// - Receive data changes on rising clock edge, falling edge when clock inverted.
// - Receive data inversion applies to channel and drop port data.
// - In E3 mode channels 17 to 28 outputs are unused.
// - In G.747 mode every fourth channel output is unused.
// - Mux disabled makes every receive output, drop ports too, meaningless.
// - Two drop ports carry a selected channel with same edge and inversion.
// - Common receive clock enable slaves all receive clocks to one input.
// - Transmit data sampled on falling clock edge, rising when clock inverted.
// - Transmit data inversion applies to channel and insert data.
// - In E3 mode transmit channels 17 to 28 are ignored, tied low.
// - In G.747 mode every fourth transmit channel is ignored, tied low.
// - Two insert ports with own clocks replace a selected channel.
// - Mux disabled ignores all transmit and insert inputs.
// - Common transmit clock enable samples all data on the common clock.
// - Line data sampled on rising line clock edge, falling when inverted.
// - Status updates need the line clock, except both clock-loss indications.
module tlrx_port_io
  import tlrx_pkg::*;
#(
  parameter int N_CH = 28
)(
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [N_CH-1:0]   rx_core_clk,
  input  wire logic [N_CH-1:0]   rx_core_data,
  output logic      [N_CH-1:0]   trib_rx_data_out,
  output logic      [N_CH-1:0]   trib_rx_clock_out,
  output logic      [1:0]        drop_port_data_out,
  output logic      [1:0]        drop_port_clock_out,
  input  wire logic              rx_common_clock_in,
  input  wire logic [N_CH-1:0]   trib_tx_data_in,
  input  wire logic [N_CH-1:0]   trib_tx_clock_in,
  input  wire logic [1:0]        insert_port_data_in,
  input  wire logic [1:0]        insert_port_clock_in,
  input  wire logic              tx_common_clock_in,
  output logic      [N_CH-1:0]   tx_bit_out,
  output logic      [N_CH-1:0]   tx_bit_valid,
  input  wire logic [1:0]        line_rx_pos_neg_data,
  input  wire logic              line_rx_clock,
  output logic      [1:0]        line_rx_bits_out,
  output logic                   line_rx_strobe_out,
  output logic                   rx_clock_loss_status,
  output logic                   tx_clock_loss_status
);
  localparam int B  = 2 * N_CH;
  localparam int SW = B + 9;

  if (N_CH <= E3_CHANNELS || N_CH > 32 || N_CH % G747_GROUP != 0)
  begin : g_bad
    $error("N_CH must be a multiple of 4 above 16 and at most 32");
  end

  // Every pin-side input passes two flops before use
  logic [SW-1:0] s1_ff, s2_ff;
  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
    begin
      s1_ff <= '0;
      s2_ff <= '0;
    end
    else
    begin
      s1_ff <= {line_rx_pos_neg_data, line_rx_clock, tx_common_clock_in, rx_common_clock_in,
                insert_port_data_in, insert_port_clock_in, trib_tx_data_in, trib_tx_clock_in};
      s2_ff <= s1_ff;
    end

  wire logic [N_CH-1:0] tx_clk_s  = s2_ff[N_CH-1:0];
  wire logic [N_CH-1:0] tx_dat_s  = s2_ff[B-1:N_CH];
  wire logic [1:0]      ins_clk_s = s2_ff[B+1:B];
  wire logic [1:0]      ins_dat_s = s2_ff[B+3:B+2];
  wire logic            rcc_s     = s2_ff[B+4];
  wire logic            tcc_s     = s2_ff[B+5];
  wire logic            lclk_s    = s2_ff[B+6];
  wire logic [1:0]      lbits_s   = s2_ff[B+8:B+7];

  // Register file and APB slave, one wait state per access
  tlrx_ctrl_t  ctrl_ff, nxt_ctrl;
  tlrx_sel_t   sel_ff, nxt_sel;
  logic [31:0] prdata_ff, nxt_prdata;
  logic        pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
  logic [CNT_W-1:0] lcnt_ff;
  logic        rloss_ff, tloss_ff;
  wire logic   acc  = psel & penable;
  wire logic   done = acc & pready_ff;

  always_comb
  begin
    nxt_ctrl    = ctrl_ff;
    nxt_sel     = sel_ff;
    nxt_prdata  = prdata_ff;
    nxt_pslverr = pslverr_ff;
    nxt_pready  = acc & ~pready_ff;
    if (done && pwrite)
    begin
      case (paddr)
        CTRL_OFS: nxt_ctrl = tlrx_ctrl_t'(pwdata[CTRL_W-1:0]);
        SEL_OFS:  nxt_sel = tlrx_sel_t'(pwdata[SELR_W-1:0]);
        default:  nxt_ctrl = ctrl_ff;
      endcase
    end
    if (acc && !pready_ff)
    begin
      nxt_prdata  = '0;
      nxt_pslverr = 1'b0;
      case (paddr)
        CTRL_OFS: nxt_prdata = pwrite ? '0 : 32'(ctrl_ff);
        SEL_OFS:  nxt_prdata = pwrite ? '0 : 32'(sel_ff);
        STAT_OFS: nxt_prdata = pwrite ? '0 : {16'h0000, lcnt_ff, 6'h00, tloss_ff, rloss_ff};
        default:  nxt_pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
    begin
      ctrl_ff    <= CTRL_RST;
      sel_ff     <= SEL_RST;
      prdata_ff  <= '0;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      ctrl_ff    <= nxt_ctrl;
      sel_ff     <= nxt_sel;
      prdata_ff  <= nxt_prdata;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end

  // Per-channel receive and transmit paths
  logic [N_CH-1:0] rx_src, rx_src_ff, nxt_rxd, nxt_rxc, rxd_ff, rxc_ff;
  logic [N_CH-1:0] tx_e, tx_e_ff, tx_samp, tx_dat_x, nxt_txb, txb_ff, txv_ff;
  logic [1:0]      nxt_dpd, nxt_dpc, dpd_ff, dpc_ff;

  genvar i;
  for (i = 0; i < N_CH; i++)
  begin : g_ch
    wire logic used = chan_used(i, ctrl_ff);
    wire logic ia   = sel_ff.ins_a_en && sel_ff.ins_a == SEL_W'(i);
    wire logic ib   = sel_ff.ins_b_en && sel_ff.ins_b == SEL_W'(i);
    assign rx_src[i]  = ctrl_ff.rx_cc_en ? rcc_s : rx_core_clk[i];
    assign nxt_rxc[i] = used & (rx_src[i] ^ ctrl_ff.rx_clk_inv);
    assign nxt_rxd[i] = !used ? 1'b0 :
                        (rx_src[i] && !rx_src_ff[i]) ? rx_core_data[i] ^ ctrl_ff.rx_dat_inv :
                        rxd_ff[i];
    wire logic tclk = ctrl_ff.tx_cc_en ? tcc_s : ia ? ins_clk_s[0] :
                      ib ? ins_clk_s[1] : tx_clk_s[i];
    wire logic tdat = ia ? ins_dat_s[0] : ib ? ins_dat_s[1] : tx_dat_s[i];
    // sample on falling edge of e
    assign tx_e[i]     = used & (tclk ^ ctrl_ff.tx_clk_inv);
    assign tx_samp[i]  = used & tx_e_ff[i] & ~tx_e[i];
    assign tx_dat_x[i] = tdat ^ ctrl_ff.tx_dat_inv;
    assign nxt_txb[i]  = tx_samp[i] ? tx_dat_x[i] : txb_ff[i];
  end

  genvar k;
  for (k = 0; k < 2; k++)
  begin : g_drop
    wire logic [SEL_W-1:0] d = k ? sel_ff.drop_b : sel_ff.drop_a;
    assign nxt_dpd[k] = (d < SEL_W'(N_CH)) ? nxt_rxd[d] : 1'b0;
    assign nxt_dpc[k] = (d < SEL_W'(N_CH)) ? nxt_rxc[d] : 1'b0;
  end

  // A toggled invert bit may give one stray edge; software changes it while idle
  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
    begin
      rx_src_ff <= '0;
      rxd_ff    <= '0;
      rxc_ff    <= '0;
      dpd_ff    <= '0;
      dpc_ff    <= '0;
      tx_e_ff   <= '0;
      txb_ff    <= '0;
      txv_ff    <= '0;
    end
    else
    begin
      rx_src_ff <= rx_src;
      rxd_ff    <= nxt_rxd;
      rxc_ff    <= nxt_rxc;
      dpd_ff    <= nxt_dpd;
      dpc_ff    <= nxt_dpc;
      tx_e_ff   <= tx_e;
      txb_ff    <= nxt_txb;
      txv_ff    <= tx_samp;
    end

  // Line sampling, clock-loss detection and line status
  logic             le_ff, lstb_ff, tloss_nx, rloss_nx;
  logic [1:0]       lbits_ff, nxt_lbits;
  logic [CNT_W-1:0] rcnt_ff, tcnt_ff, nxt_rcnt, nxt_tcnt, nxt_lcnt;
  localparam logic [CNT_W-1:0] LOSS_MAX = CNT_W'(LOSS_CYC);
  wire logic le        = lclk_s ^ ctrl_ff.line_clk_inv;
  // rise of e is the sampling edge
  wire logic line_samp = le & ~le_ff;
  wire logic tx_tog    = |(tx_e ^ tx_e_ff);

  always_comb
  begin
    nxt_rcnt  = (le != le_ff) ? '0 : (rcnt_ff == LOSS_MAX) ? rcnt_ff : rcnt_ff + 1'b1;
    nxt_tcnt  = tx_tog ? '0 : (tcnt_ff == LOSS_MAX) ? tcnt_ff : tcnt_ff + 1'b1;
    rloss_nx  = nxt_rcnt == LOSS_MAX;
    tloss_nx  = nxt_tcnt == LOSS_MAX;
    nxt_lbits = line_samp ? lbits_s : lbits_ff;
    // status counts only on line clock edges
    nxt_lcnt  = (line_samp && |lbits_s) ? lcnt_ff + 1'b1 : lcnt_ff;
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
    begin
      le_ff    <= 1'b0;
      lstb_ff  <= 1'b0;
      lbits_ff <= '0;
      lcnt_ff  <= '0;
      rcnt_ff  <= '0;
      tcnt_ff  <= '0;
      rloss_ff <= 1'b0;
      tloss_ff <= 1'b0;
    end
    else
    begin
      le_ff    <= le;
      lstb_ff  <= line_samp;
      lbits_ff <= nxt_lbits;
      lcnt_ff  <= nxt_lcnt;
      rcnt_ff  <= nxt_rcnt;
      tcnt_ff  <= nxt_tcnt;
      rloss_ff <= rloss_nx;
      tloss_ff <= tloss_nx;
    end

  assign prdata               = prdata_ff;
  assign pready               = pready_ff;
  assign pslverr              = pslverr_ff;
  assign trib_rx_data_out     = rxd_ff;
  assign trib_rx_clock_out    = rxc_ff;
  assign drop_port_data_out   = dpd_ff;
  assign drop_port_clock_out  = dpc_ff;
  assign tx_bit_out           = txb_ff;
  assign tx_bit_valid         = txv_ff;
  assign line_rx_bits_out     = lbits_ff;
  assign line_rx_strobe_out   = lstb_ff;
  assign rx_clock_loss_status = rloss_ff;
  assign tx_clock_loss_status = tloss_ff;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  property p_rx_e3;
    ctrl_ff.e3 |=> trib_rx_clock_out[N_CH-1:E3_CHANNELS] == '0;
  endproperty
  a_rx_e3: assert property (p_rx_e3) else $error("E3 unused rx clock active");
  property p_rx_g747;
    ctrl_ff.g747 |=> !trib_rx_data_out[3] && !trib_rx_clock_out[7];
  endproperty
  a_rx_g747: assert property (p_rx_g747) else $error("G747 unused rx active");
  property p_rx_off;
    !ctrl_ff.mux_en |=> trib_rx_data_out == '0 && drop_port_clock_out == '0;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("rx outputs active when off");
  property p_rx_edge;
    ctrl_ff.mux_en && rx_src[0] && !rx_src_ff[0] |=>
      trib_rx_clock_out[0] == !$past(ctrl_ff.rx_clk_inv)
      && trib_rx_data_out[0] == ($past(rx_core_data[0]) ^ $past(ctrl_ff.rx_dat_inv));
  endproperty
  a_rx_edge: assert property (p_rx_edge) else $error("rx data or clock edge wrong");
  property p_drop;
    sel_ff.drop_a < SEL_W'(N_CH) |=> drop_port_data_out[0] ==
      trib_rx_data_out[$past(sel_ff.drop_a)];
  endproperty
  a_drop: assert property (p_drop) else $error("drop port not copying channel");
  property p_tx_samp;
    tx_samp[0] |=> tx_bit_valid[0] && tx_bit_out[0] == $past(tx_dat_x[0]);
  endproperty
  a_tx_samp: assert property (p_tx_samp) else $error("tx sample lost");
  property p_tx_e3;
    ctrl_ff.e3 |=> tx_bit_valid[N_CH-1:E3_CHANNELS] == '0;
  endproperty
  a_tx_e3: assert property (p_tx_e3) else $error("E3 unused tx sampled");
  property p_tx_off;
    !ctrl_ff.mux_en |=> tx_bit_valid == '0;
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("tx sampled when off");
  property p_line;
    line_samp |=> line_rx_strobe_out ##1 !line_rx_strobe_out;
  endproperty
  a_line: assert property (p_line) else $error("line strobe not one cycle");
  property p_stat_hold;
    rx_clock_loss_status && !line_samp |=> $stable(lcnt_ff);
  endproperty
  a_stat_hold: assert property (p_stat_hold) else $error("status moved without clock");
  property p_apb;
    acc && !pready_ff |=> pready ##1 !pready;
  endproperty
  a_apb: assert property (p_apb) else $error("APB answer timing wrong");
  c_drop: cover property (ctrl_ff.mux_en && $rose(drop_port_clock_out[0]));
  c_ins: cover property (sel_ff.ins_a_en && tx_samp[sel_ff.ins_a]);
  c_loss: cover property ($rose(rx_clock_loss_status));
endmodule
`default_nettype wire

// ### hdl/tlrx_pkg.sv
// Constants, register layout and carrier types of the tributary and line port block
package tlrx_pkg;
  localparam int CLK_NS      = 40;
  // A clock with no edge for this long is reported as lost
  localparam int LOSS_NS     = 2000;
  localparam int LOSS_CYC    = (LOSS_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W       = 8;
  localparam int E3_CHANNELS = 16;
  localparam int G747_GROUP  = 4;
  localparam int SEL_W       = 5;
  localparam int CTRL_W      = 10;
  localparam int SELR_W      = 22;
  localparam int STAT_CNT_LSB = 8;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] SEL_OFS  = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;

  // Packed so that bit 0 of the control word is mux_en
  typedef struct packed {
    logic line_clk_inv;
    logic tx_cc_en;
    logic tx_dat_inv;
    logic tx_clk_inv;
    logic rx_cc_en;
    logic rx_dat_inv;
    logic rx_clk_inv;
    logic g747;
    logic e3;
    logic mux_en;
  } tlrx_ctrl_t;

  typedef struct packed {
    logic             ins_b_en;
    logic             ins_a_en;
    logic [SEL_W-1:0] ins_b;
    logic [SEL_W-1:0] ins_a;
    logic [SEL_W-1:0] drop_b;
    logic [SEL_W-1:0] drop_a;
  } tlrx_sel_t;

  localparam tlrx_ctrl_t CTRL_RST = '0;
  localparam tlrx_sel_t  SEL_RST  = '0;

  // Channel carries traffic in the current mode
  function automatic logic chan_used(input int idx, input tlrx_ctrl_t c);
    chan_used = c.mux_en && !(c.e3 && idx >= E3_CHANNELS)
                && !(c.g747 && (idx % G747_GROUP) == G747_GROUP - 1);
  endfunction
endpackage

// ### testbench/tlrx_far_end.sv
// Far-end model: tributary framers and line interface feeding the port block
`timescale 1ns/1ps
`default_nettype none
module tlrx_far_end
  import tlrx_pkg::*;
#(
  parameter int N_CH = 28
)(
  input  wire logic            run,
  input  wire tlrx_ctrl_t      ctrl,
  input  wire logic [N_CH-1:0] mask,
  input  wire logic [N_CH+3:0] pat,
  output logic                 lk,
  output logic [N_CH-1:0]      trib_tx_clock_in,
  output logic [N_CH-1:0]      trib_tx_data_in,
  output logic [1:0]           insert_port_clock_in,
  output logic [1:0]           insert_port_data_in,
  output logic                 tx_common_clock_in,
  output logic                 line_rx_clock,
  output logic [1:0]           line_rx_pos_neg_data
);
  logic free_clk = 1'b0;
  logic en       = 1'b0;
  always #160 free_clk = ~free_clk;
  // Gated only while low, so the pins never see a runt pulse
  always @(negedge free_clk) en <= run;
  assign lk = en & free_clk;
  assign line_rx_clock = lk;
  assign tx_common_clock_in = ctrl.tx_cc_en & lk;
  assign trib_tx_clock_in = ctrl.tx_cc_en ? '0 : {N_CH{lk}} & mask;
  assign insert_port_clock_in = ctrl.tx_cc_en ? 2'b00 : {2{lk & mask[0]}};
  // data moves away from the sampling edge, lines outside mask low
  always @(free_clk)
    if (free_clk != ctrl.tx_clk_inv)
    begin
      trib_tx_data_in     <= pat[N_CH-1:0] & mask;
      insert_port_data_in <= pat[N_CH+1:N_CH] & {2{mask[0]}};
    end
  // Line pair idles low, so a stray sample from an invert change counts nothing
  always @(free_clk)
    if (free_clk == ctrl.line_clk_inv)
      line_rx_pos_neg_data <= run ? pat[N_CH+3:N_CH+2] : 2'b00;
  initial
  begin
    trib_tx_data_in      = '0;
    insert_port_data_in  = '0;
    line_rx_pos_neg_data = '0;
  end
endmodule
`default_nettype wire

// ### testbench/tb_tributary_and_line_rx_port_io.sv
// Self-checking bench for the tributary and line port block
`timescale 1ns/1ps
`default_nettype none
module tb_tributary_and_line_rx_port_io;
  import tlrx_pkg::*;
  localparam int N = 28;
  logic         ref_clk = 1'b0;
  logic         sys_rst = 1'b1;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [7:0]   paddr = '0;
  logic [31:0]  pwdata = '0;
  logic [31:0]  prdata;
  logic         pready, pslverr, lk, rx_common_clock_in, tx_common_clock_in;
  logic [N-1:0] rx_core_clk = '0;
  logic [N-1:0] rx_core_data = '0;
  logic [N-1:0] trib_rx_data_out, trib_rx_clock_out, trib_tx_data_in, trib_tx_clock_in;
  logic [N-1:0] tx_bit_out, tx_bit_valid, used, prev_src, exp_clk, exp_dat, rose;
  logic [1:0]   drop_port_data_out, drop_port_clock_out, insert_port_data_in;
  logic [1:0]   insert_port_clock_in, line_rx_pos_neg_data, line_rx_bits_out;
  logic         line_rx_clock, line_rx_strobe_out, rx_clock_loss_status, tx_clock_loss_status;
  logic         run = 1'b0;
  logic         rude = 1'b0;
  logic [31:0]  rnd = 32'h244E;
  logic [5:0]   pd = '0;
  logic [7:0]   cnt = '0;
  tlrx_ctrl_t   ctrl = CTRL_RST;
  tlrx_sel_t    sel = SEL_RST;
  logic         q_tx [N][$];
  logic [1:0]   q_ln [$];
  int           num_errors = 0;
  int           n_compared = 0;
  int           cyc = 0;
  logic [9:0]   cfg [8] = '{10'h001, 10'h003, 10'h005, 10'h2D9, 10'h121, 10'h1E9, 10'h007, 10'h000};

  tlrx_port_io #(.N_CH(N)) tlrx_port_io_i (
    .ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .rx_core_clk, .rx_core_data, .trib_rx_data_out, .trib_rx_clock_out, .drop_port_data_out,
    .drop_port_clock_out, .rx_common_clock_in, .trib_tx_data_in, .trib_tx_clock_in,
    .insert_port_data_in, .insert_port_clock_in, .tx_common_clock_in, .tx_bit_out,
    .tx_bit_valid, .line_rx_pos_neg_data, .line_rx_clock, .line_rx_bits_out,
    .line_rx_strobe_out, .rx_clock_loss_status, .tx_clock_loss_status);
  tlrx_far_end #(.N_CH(N)) tlrx_far_end_i (
    .run, .ctrl, .mask(used | {N{rude}}), .pat(rnd), .lk, .trib_tx_clock_in, .trib_tx_data_in,
    .insert_port_clock_in, .insert_port_data_in, .tx_common_clock_in, .line_rx_clock,
    .line_rx_pos_neg_data);

  always #20 ref_clk = ~ref_clk;
  // common receive clock held low unless in use
  assign rx_common_clock_in = ctrl.rx_cc_en & lk;
  assign used = mask_of(ctrl);

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [N-1:0] mask_of(input tlrx_ctrl_t c);
    for (int i = 0; i < N; i++)
      mask_of[i] = c.mux_en && !(c.e3 && i >= 16) && !(c.g747 && i % 4 == 3);
  endfunction
  // insert ports replace their chosen channel
  function automatic logic tx_src(input int i);
    if (sel.ins_a_en && sel.ins_a == i) tx_src = insert_port_data_in[0];
    else if (sel.ins_b_en && sel.ins_b == i) tx_src = insert_port_data_in[1];
    else tx_src = trib_tx_data_in[i];
  endfunction

  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    n_compared++;
    if (g !== e)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    @(posedge ref_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (w && a == CTRL_OFS) ctrl <= tlrx_ctrl_t'(d[CTRL_W-1:0]);
    if (w && a == SEL_OFS) sel <= tlrx_sel_t'(d[SELR_W-1:0]);
  endtask
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e, input logic ee);
    logic [31:0] q;
    logic        err;
    apb(1'b0, a, 32'h0, q, err);
    chk(n, e, q);
    chk("read error flag", ee, err);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
    logic [31:0] q;
    logic        err;
    apb(1'b1, a, d, q, err);
    chk("write error flag", ee, err);
  endtask
  task automatic end_of_test();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    rnd          <= lfsr(rnd);
    rx_core_clk  <= rnd[N-1:0];
    rx_core_data <= rnd[31:32-N];
    rose         <= rx_core_clk & ~prev_src & used;
    prev_src     <= rx_core_clk;
    exp_clk      <= (rx_core_clk ^ {N{ctrl.rx_clk_inv}}) & used;
    exp_dat      <= (rx_core_data ^ {N{ctrl.rx_dat_inv}}) & used;
    pd           <= {pd[4:0], psel | sys_rst};
    cyc          <= cyc + 1;
    if (cyc == 10000)
    begin
      num_errors++;
      end_of_test();
    end
  end
  // Record what each sampling edge should capture
  always @(lk)
  begin
    if (lk != ctrl.line_clk_inv)
    begin
      q_ln.push_back(line_rx_pos_neg_data);
      cnt = cnt + 8'(|line_rx_pos_neg_data);
    end
    if (lk == ctrl.tx_clk_inv)
      for (int i = 0; i < N; i++)
        if (used[i])
          q_tx[i].push_back(tx_src(i) ^ ctrl.tx_dat_inv);
  end
  // Skipped for a few cycles after a register access, while settings change
  always @(negedge ref_clk)
    if (pd == 0 && !psel)
    begin
      int k;
      if (!ctrl.rx_cc_en)
      begin
        chk("rx clock", exp_clk, trib_rx_clock_out);
        chk("rx data", exp_dat & rose, trib_rx_data_out & (rose | ~used));
        for (int p = 0; p < 2; p++)
        begin
          k = p ? sel.drop_b : sel.drop_a;
          chk("drop clock", (k < N) ? exp_clk[k] : 1'b0, drop_port_clock_out[p]);
          if (k < N && rose[k]) chk("drop data", exp_dat[k], drop_port_data_out[p]);
        end
      end
      else
        chk("common rx clock", {N{trib_rx_clock_out[0]}} & used, trib_rx_clock_out & used);
      for (int i = 0; i < N; i++)
        if (tx_bit_valid[i] === 1'b1)
          chk("tx bit", q_tx[i].size() ? q_tx[i].pop_front() : 1'bx, tx_bit_out[i]);
      if (line_rx_strobe_out === 1'b1)
        chk("line pair", q_ln.size() ? q_ln.pop_front() : 2'bxx, line_rx_bits_out);
    end

  initial
  begin
    tlrx_sel_t  s;
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(negedge ref_clk);
    chk("rx pins after reset", 64'h0, {trib_rx_clock_out, trib_rx_data_out});
    rd_chk("ctrl reset", CTRL_OFS, 32'h0, 1'b0);
    rd_chk("sel reset", SEL_OFS, 32'h0, 1'b0);
    wr(STAT_OFS, 32'hFFFFFFFF, 1'b0);
    rd_chk("stat kept", STAT_OFS, 32'h0, 1'b0);
    rd_chk("unmapped", 8'h0C, 32'h0, 1'b1);
    wr(8'h02, 32'h1, 1'b1);
    rd_chk("ctrl kept", CTRL_OFS, 32'h0, 1'b0);
    foreach (cfg[m])
    begin
      rude <= m[0];
      s = tlrx_sel_t'(rnd[SELR_W-1:0] | 22'h300000);
      s.ins_b = s.ins_a ^ 5'h01;
      wr(SEL_OFS, {10'h0, s}, 1'b0);
      wr(CTRL_OFS, {22'h0, cfg[m]}, 1'b0);
      rd_chk("sel", SEL_OFS, {10'h0, s}, 1'b0);
      rd_chk("ctrl", CTRL_OFS, {22'h0, cfg[m]}, 1'b0);
      run <= 1'b1;
      repeat (400) @(posedge ref_clk);
      if (ctrl.mux_en) chk("loss running", 64'h0, {rx_clock_loss_status, tx_clock_loss_status});
      run <= 1'b0;
      repeat (30) @(posedge ref_clk);
    end
    repeat (60) @(posedge ref_clk);
    chk("loss stopped", 64'h3, {rx_clock_loss_status, tx_clock_loss_status});
    rd_chk("stat", STAT_OFS, {16'h0, cnt, 8'h03}, 1'b0);
    end_of_test();
  end
endmodule
`default_nettype wire
